/* design/asm_pkg.sv */
// Constants for the amplifier status and monitor register bank
// Summary of operation
// RQ1 - Master clock halt latches bit 4 of clock fault status; cleared by read.
// RQ2 - Bit 2 reads 1 while frame and bit clocks are both absent.
// RQ3 - Bit 1 reads 1 while clock resynchronization is in progress.
// RQ4 - Clock error latches bit 0 of clock fault status; cleared by read.
// RQ5 - Bits 7..5 and 3 of clock fault status are plain storage, reset zero.
// RQ6 - Mute monitor bit 1 shows left analog mute: 0 muted, 1 unmuted.
// RQ7 - Mute monitor bit 0 shows right analog mute: 0 muted, 1 unmuted.
// RQ8 - Pin level bit 5 shows general-purpose pin 2 level.
// RQ9 - Pin level bit 4 shows external mute pin level.
// RQ10 - Pin level bit 3 shows pin 0 level; bits 2..0 read-only, no function.
// RQ11 - Auto-mute flags bit 4 reads 1 while left channel is auto-muted.
// RQ12 - Auto-mute flags bit 0 reads 1 while right channel is auto-muted.
// RQ13 - Page 1 offset 0x01 bit 0 selects amplitude type, reset 0.
// RQ14 - Host disables clock auto-set when common-mode mode runs with the PLL.
// RQ15 - An event coinciding with the clearing read keeps its flag set.
package asm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ASM_PAGE0 = 8'h00;
  localparam logic [7:0] ASM_PAGE1 = 8'h01;
  localparam logic [6:0] ASM_OFF_CLK_FAULT = 7'h5F;
  localparam logic [6:0] ASM_OFF_MUTE_MON = 7'h6C;
  localparam logic [6:0] ASM_OFF_PIN_LEVEL = 7'h77;
  localparam logic [6:0] ASM_OFF_AUTO_MUTE = 7'h78;
  localparam logic [6:0] ASM_OFF_AMP_SEL = 7'h01;
  localparam logic [6:0] ASM_OFF_PAGE_SEL = 7'h00;
  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int ASM_BIT_HALT = 4;
  localparam int ASM_BIT_MISSING = 2;
  localparam int ASM_BIT_RESYNC = 1;
  localparam int ASM_BIT_CLKERR = 0;
  localparam logic [7:0] ASM_CLK_FAULT_RW_MASK = 8'hE8;
  localparam logic [7:0] ASM_MUTE_MON_RW_MASK = 8'hFC;
  localparam logic [7:0] ASM_PIN_LEVEL_RW_MASK = 8'hC0;
  localparam logic [7:0] ASM_AUTO_MUTE_RW_MASK = 8'hEE;
  localparam logic [7:0] ASM_AMP_SEL_RW_MASK = 8'hFF;
  localparam int ASM_BIT_LEFT_MUTE = 1;
  localparam int ASM_BIT_RIGHT_MUTE = 0;
  localparam int ASM_BIT_GP2 = 5;
  localparam int ASM_BIT_MUTE_PIN = 4;
  localparam int ASM_BIT_GP0 = 3;
  localparam int ASM_BIT_LEFT_AUTO = 4;
  localparam int ASM_BIT_RIGHT_AUTO = 0;
  localparam int ASM_BIT_AMP_TYPE = 0;
  localparam logic [7:0] ASM_RESET_VAL = 8'h00;
  localparam logic [7:0] ASM_ZERO = 8'h00;
endpackage : asm_pkg

/* design/asm_event_latch.sv */
// Sticky event flag cleared by a read, where a new event wins over the clear
`timescale 1ns/1ns
module asm_event_latch
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Event and clear
  input wire logic eventIn,
  input wire logic clearReq,
  // Flag
  output logic flagOut
);
  // Set has priority so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flagOut <= 1'b0;
    else if (clkEn)
    begin
      if (eventIn)
        flagOut <= 1'b1; // RQ15
      else if (clearReq)
        flagOut <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  event_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    clkEn && eventIn |=> flagOut)
    else $error("event flag not set after event");
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1 RQ4
    clkEn && clearReq && !eventIn |=> !flagOut)
    else $error("event flag not cleared by read");
endmodule : asm_event_latch

/* design/asm_status_monitor.sv */
// Status and monitor register bank of the amplifier control port
`timescale 1ns/1ns
module asm_status_monitor
  import asm_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register access from the control port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  // Clock detector status
  input wire logic mclkHaltEvent,
  input wire logic frameClkPresent,
  input wire logic bitClkPresent,
  input wire logic clockResyncActive,
  input wire logic clockErrorEvent,
  // Mute engine and pins
  input wire logic leftAnalogUnmuted,
  input wire logic rightAnalogUnmuted,
  input wire logic gpPin2Level,
  input wire logic mutePinLevel,
  input wire logic gpPin0Level,
  input wire logic leftAutoMuteFlag,
  input wire logic rightAutoMuteFlag,
  // Read data and controls
  output logic [7:0] regRdata,
  output logic regRvalid,
  output logic outputAmplitudeType,
  output logic [7:0] pageSelect
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] clkFaultRw_reg;
  logic [7:0] muteMonRw_reg;
  logic [7:0] pinLevelRw_reg;
  logic [7:0] autoMuteRw_reg;
  logic [7:0] ampSel_reg;
  logic latchedMclkHalt;
  logic latchedClockError;
  logic serialClocksMissing_reg;
  logic clockResyncActive_reg;
  logic [7:0] statusLive_reg;
  logic [7:0] autoLive_reg;
  logic onPage0;
  logic onPage1;
  logic readFault;
  logic [7:0] readData_next;

  assign onPage0 = (pageSelect == ASM_PAGE0);
  assign onPage1 = (pageSelect == ASM_PAGE1);
  // Reading the fault register clears both latched flags
  assign readFault = regRead && onPage0 && (regAddr == ASM_OFF_CLK_FAULT);

  // ****************************************
  // Latched events
  // ****************************************
  asm_event_latch haltLatch
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .eventIn(mclkHaltEvent), // RQ1
    .clearReq(readFault),
    .flagOut(latchedMclkHalt)
  );

  asm_event_latch errorLatch
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .eventIn(clockErrorEvent), // RQ4
    .clearReq(readFault),
    .flagOut(latchedClockError)
  );

  // Live clock levels registered so the read word is flop based
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serialClocksMissing_reg <= 1'b0;
      clockResyncActive_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      serialClocksMissing_reg <= !frameClkPresent && !bitClkPresent; // RQ2
      clockResyncActive_reg <= clockResyncActive; // RQ3
    end
  end

  // Live monitor word: mute state, pins and auto-mute flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      statusLive_reg <= ASM_RESET_VAL;
      autoLive_reg <= ASM_RESET_VAL;
    end
    else if (clkEn)
    begin
      statusLive_reg <= ASM_ZERO;
      autoLive_reg <= ASM_ZERO;
      statusLive_reg[ASM_BIT_LEFT_MUTE] <= leftAnalogUnmuted; // RQ6
      statusLive_reg[ASM_BIT_RIGHT_MUTE] <= rightAnalogUnmuted; // RQ7
      statusLive_reg[ASM_BIT_GP2] <= gpPin2Level; // RQ8
      statusLive_reg[ASM_BIT_MUTE_PIN] <= mutePinLevel; // RQ9
      statusLive_reg[ASM_BIT_GP0] <= gpPin0Level; // RQ10
      autoLive_reg[ASM_BIT_LEFT_AUTO] <= leftAutoMuteFlag; // RQ11
      autoLive_reg[ASM_BIT_RIGHT_AUTO] <= rightAutoMuteFlag; // RQ12
    end
  end

  // ****************************************
  // Writable storage
  // ****************************************
  // Only bits marked writable take host data; status bits stay hardware owned
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkFaultRw_reg <= ASM_RESET_VAL;
      muteMonRw_reg <= ASM_RESET_VAL;
      pinLevelRw_reg <= ASM_RESET_VAL;
      autoMuteRw_reg <= ASM_RESET_VAL;
      ampSel_reg <= ASM_RESET_VAL;
      pageSelect <= ASM_PAGE0;
    end
    else if (clkEn && regWrite)
    begin
      if (regAddr == ASM_OFF_PAGE_SEL)
        pageSelect <= regWdata;
      else if (onPage0)
      begin
        unique case (regAddr)
          ASM_OFF_CLK_FAULT: clkFaultRw_reg <= regWdata & ASM_CLK_FAULT_RW_MASK; // RQ5
          ASM_OFF_MUTE_MON: muteMonRw_reg <= regWdata & ASM_MUTE_MON_RW_MASK;
          ASM_OFF_PIN_LEVEL: pinLevelRw_reg <= regWdata & ASM_PIN_LEVEL_RW_MASK;
          ASM_OFF_AUTO_MUTE: autoMuteRw_reg <= regWdata & ASM_AUTO_MUTE_RW_MASK;
          default: ;
        endcase
      end
      else if (onPage1 && regAddr == ASM_OFF_AMP_SEL)
        ampSel_reg <= regWdata & ASM_AMP_SEL_RW_MASK; // RQ13
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read word assembly; unmapped addresses read zero
  always_comb
  begin
    readData_next = ASM_ZERO;
    if (regAddr == ASM_OFF_PAGE_SEL)
      readData_next = pageSelect;
    else if (onPage0)
    begin
      unique case (regAddr)
        ASM_OFF_CLK_FAULT:
        begin
          readData_next = clkFaultRw_reg;
          readData_next[ASM_BIT_HALT] = latchedMclkHalt; // RQ1
          readData_next[ASM_BIT_MISSING] = serialClocksMissing_reg; // RQ2
          readData_next[ASM_BIT_RESYNC] = clockResyncActive_reg; // RQ3
          readData_next[ASM_BIT_CLKERR] = latchedClockError; // RQ4
        end
        ASM_OFF_MUTE_MON:
        begin
          readData_next = muteMonRw_reg;
          readData_next[ASM_BIT_LEFT_MUTE] = statusLive_reg[ASM_BIT_LEFT_MUTE]; // RQ6
          readData_next[ASM_BIT_RIGHT_MUTE] = statusLive_reg[ASM_BIT_RIGHT_MUTE]; // RQ7
        end
        ASM_OFF_PIN_LEVEL:
        begin
          readData_next = pinLevelRw_reg;
          readData_next[ASM_BIT_GP2] = statusLive_reg[ASM_BIT_GP2]; // RQ8
          readData_next[ASM_BIT_MUTE_PIN] = statusLive_reg[ASM_BIT_MUTE_PIN]; // RQ9
          readData_next[ASM_BIT_GP0] = statusLive_reg[ASM_BIT_GP0]; // RQ10
        end
        ASM_OFF_AUTO_MUTE:
        begin
          readData_next = autoMuteRw_reg;
          readData_next[ASM_BIT_LEFT_AUTO] = autoLive_reg[ASM_BIT_LEFT_AUTO]; // RQ11
          readData_next[ASM_BIT_RIGHT_AUTO] = autoLive_reg[ASM_BIT_RIGHT_AUTO]; // RQ12
        end
        default: readData_next = ASM_ZERO;
      endcase
    end
    else if (onPage1 && regAddr == ASM_OFF_AMP_SEL)
      readData_next = ampSel_reg; // RQ13
  end

  // Read data captured one cycle after the read request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= ASM_ZERO;
      regRvalid <= 1'b0;
    end
    else if (clkEn)
    begin
      regRvalid <= regRead;
      if (regRead)
        regRdata <= readData_next;
    end
  end

  // Amplitude type drives the analog front end; host owns the auto-set hazard
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      outputAmplitudeType <= 1'b0;
    else if (clkEn)
      outputAmplitudeType <= ampSel_reg[ASM_BIT_AMP_TYPE]; // RQ13 RQ14
  end

  // ****************************************
  // Checks
  // ****************************************
  halt_read_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    clkEn && mclkHaltEvent ##1 clkEn && readFault |=> regRdata[ASM_BIT_HALT])
    else $error("halt flag missing on read");
  clocks_missing_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    clkEn && !frameClkPresent && !bitClkPresent ##1 clkEn && readFault
    |=> regRdata[ASM_BIT_MISSING])
    else $error("clocks missing not reported");
  resync_read_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    clkEn && readFault |=> regRdata[ASM_BIT_RESYNC] == $past(clockResyncActive_reg))
    else $error("resync bit wrong on read");
  error_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    clkEn && readFault && !clockErrorEvent ##1 clkEn && readFault && !clockErrorEvent
    |=> !regRdata[ASM_BIT_CLKERR])
    else $error("clock error not cleared by read");
  reserved_rw_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    clkEn && regWrite && onPage0 && regAddr == ASM_OFF_CLK_FAULT
    |=> clkFaultRw_reg == ($past(regWdata) & ASM_CLK_FAULT_RW_MASK))
    else $error("reserved storage not written");
  left_mute_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    clkEn ##1 clkEn && regRead && onPage0 && regAddr == ASM_OFF_MUTE_MON
    |=> regRdata[ASM_BIT_LEFT_MUTE] == $past(leftAnalogUnmuted, 2))
    else $error("left mute monitor wrong");
  right_mute_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    clkEn ##1 clkEn && regRead && onPage0 && regAddr == ASM_OFF_MUTE_MON
    |=> regRdata[ASM_BIT_RIGHT_MUTE] == $past(rightAnalogUnmuted, 2))
    else $error("right mute monitor wrong");
  pin_levels_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8 RQ9 RQ10
    clkEn ##1 clkEn && regRead && onPage0 && regAddr == ASM_OFF_PIN_LEVEL
    |=> regRdata[5:3] == {$past(gpPin2Level, 2), $past(mutePinLevel, 2),
    $past(gpPin0Level, 2)} && regRdata[2:0] == 3'h0)
    else $error("pin levels wrong");
  auto_mute_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11 RQ12
    clkEn ##1 clkEn && regRead && onPage0 && regAddr == ASM_OFF_AUTO_MUTE
    |=> regRdata[ASM_BIT_LEFT_AUTO] == $past(leftAutoMuteFlag, 2)
    && regRdata[ASM_BIT_RIGHT_AUTO] == $past(rightAutoMuteFlag, 2))
    else $error("auto mute flags wrong");
  amp_type_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    clkEn && regWrite && onPage1 && regAddr == ASM_OFF_AMP_SEL ##1 clkEn
    |=> outputAmplitudeType == $past(regWdata[ASM_BIT_AMP_TYPE], 2))
    else $error("amplitude type not applied");

  // ****************************************
  // Flag, page and port invariants
  // ****************************************
  // A latched flag only drops on a clearing read, so no event arriving with the enable high goes unseen
  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    clkEn && latchedMclkHalt && !readFault |=> latchedMclkHalt)
    else $error("halt flag dropped without a read");
  error_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    clkEn && latchedClockError && !readFault |=> latchedClockError)
    else $error("clock error flag dropped without a read");
  halt_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    clkEn && readFault && mclkHaltEvent |=> latchedMclkHalt)
    else $error("halt lost in clearing read");
  error_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    clkEn && readFault && clockErrorEvent |=> latchedClockError)
    else $error("clock error lost in clearing read");
  // Either serial clock alone is enough to call the clocks present
  clocks_present_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    clkEn && (frameClkPresent || bitClkPresent) |=> !serialClocksMissing_reg)
    else $error("clocks missing while one is present");
  resync_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    clkEn |=> clockResyncActive_reg == $past(clockResyncActive))
    else $error("resync level not followed");
  page_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    clkEn && regWrite && regAddr == ASM_OFF_PAGE_SEL |=> pageSelect == $past(regWdata))
    else $error("page select not written");
  amp_page0_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    clkEn && regWrite && onPage0 |=> ampSel_reg == $past(ampSel_reg))
    else $error("page 0 write reached the amplitude select");
  // Every read made with the enable high is answered exactly one cycle later
  read_answer_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ1 RQ4
    clkEn && regRead |=> regRvalid)
    else $error("read not answered");
  // A low enable freezes everything the host can see
  freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    !clkEn |=> $stable(regRdata) && $stable(outputAmplitudeType) && $stable(pageSelect))
    else $error("outputs moved while frozen");
endmodule : asm_status_monitor

/* dv/asm_host_model.sv */
// Host controller model driving the register port of the status bank
`timescale 1ns/1ns
module asm_host_model
(
  // Clock
  input wire logic clk,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  // Idle bus at time zero
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
  end

  // One-cycle write strobe; a new amplitude type is written only with
  // clock auto-set left off by the caller, as this model never enables it
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // Read strobe, then a bounded wait for the one-cycle answer
  task rd(input logic [6:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (regRvalid === 1'b1)
      begin
        d = regRdata;
        return;
      end
      @(posedge clk);
    end
    // A missing answer would hang later reads, so end the run here
    test_asm_status_monitor.n_fail++;
    test_asm_status_monitor.final_report();
  endtask : rd
endmodule : asm_host_model

/* dv/test_asm_status_monitor.sv */
// Self-checking testbench of the status and monitor register bank
`timescale 1ns/1ns
module test_asm_status_monitor;
  import asm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [11:0] st = 12'h006;
  logic regWrite, regRead, regRvalid, outputAmplitudeType;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, pageSelect, d;
  int n_fail = 0;
  int tests_run = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  // ****************************************
  // Design and host
  // ****************************************
  // st packs the detector, mute engine and pin inputs in one vector
  asm_status_monitor dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .mclkHaltEvent(st[0]), .frameClkPresent(st[1]),
    .bitClkPresent(st[2]), .clockResyncActive(st[3]),
    .clockErrorEvent(st[4]), .leftAnalogUnmuted(st[5]),
    .rightAnalogUnmuted(st[6]), .gpPin2Level(st[7]), .mutePinLevel(st[8]),
    .gpPin0Level(st[9]), .leftAutoMuteFlag(st[10]),
    .rightAutoMuteFlag(st[11]), .regRdata(regRdata),
    .regRvalid(regRvalid), .outputAmplitudeType(outputAmplitudeType),
    .pageSelect(pageSelect));
  asm_host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid));

  // ****************************************
  // Helpers
  // ****************************************
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task rc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask : rc

  // Two edges let the single input register settle before a read
  task setst(input logic [11:0] v);
    @(posedge clk);
    st <= v;
    repeat (2) @(posedge clk);
  endtask : setst

  task final_report();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    rc(ASM_OFF_MUTE_MON, 8'h00);
    chk({7'h00, outputAmplitudeType}, 8'h00);
    $display("reset values done");
  endtask : t_reset

  // Events are gone from the inputs before the first two reads, so only the latch holds them; the third read meets a new halt event
  task t_latch();
    setst(12'h017);
    setst(12'h006);
    rc(ASM_OFF_CLK_FAULT, 8'h11);
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    fork
      host.rd(ASM_OFF_CLK_FAULT, d);
      begin
        @(posedge clk);
        st <= 12'h007;
        @(posedge clk);
        st <= 12'h006;
      end
    join
    chk(d, 8'h00);
    rc(ASM_OFF_CLK_FAULT, 8'h10);
    $display("latched events done");
  endtask : t_latch

  task t_live();
    setst(12'h008);
    rc(ASM_OFF_CLK_FAULT, 8'h06);
    setst(12'h002);
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    setst(12'h006);
    host.wr(ASM_OFF_CLK_FAULT, 8'hFF);
    rc(ASM_OFF_CLK_FAULT, 8'hE8);
    host.wr(ASM_OFF_CLK_FAULT, 8'h00);
    $display("clock status done");
  endtask : t_live

  task t_mon();
    setst(12'h026);
    rc(ASM_OFF_MUTE_MON, 8'h02);
    setst(12'h046);
    rc(ASM_OFF_MUTE_MON, 8'h01);
    setst(12'h086);
    rc(ASM_OFF_PIN_LEVEL, 8'h20);
    setst(12'h106);
    rc(ASM_OFF_PIN_LEVEL, 8'h10);
    setst(12'h206);
    host.wr(ASM_OFF_PIN_LEVEL, 8'h3F);
    rc(ASM_OFF_PIN_LEVEL, 8'h08);
    setst(12'h406);
    rc(ASM_OFF_AUTO_MUTE, 8'h10);
    setst(12'h806);
    rc(ASM_OFF_AUTO_MUTE, 8'h01);
    setst(12'h006);
    $display("monitors done");
  endtask : t_mon

  // The type output trails the stored bit by one cycle
  task t_amp();
    host.wr(ASM_OFF_PAGE_SEL, ASM_PAGE1);
    rc(ASM_OFF_AMP_SEL, 8'h00);
    chk(pageSelect, ASM_PAGE1);
    rc(ASM_OFF_PAGE_SEL, ASM_PAGE1);
    host.wr(ASM_OFF_AMP_SEL, 8'hA5);
    @(posedge clk);
    #1;
    chk({7'h00, outputAmplitudeType}, 8'h01);
    rc(ASM_OFF_AMP_SEL, 8'hA5);
    host.wr(ASM_OFF_AMP_SEL, 8'hA4);
    @(posedge clk);
    #1;
    chk({7'h00, outputAmplitudeType}, 8'h00);
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    host.wr(ASM_OFF_PAGE_SEL, ASM_PAGE0);
    $display("amplitude type done");
  endtask : t_amp

  // Events and writes that arrive while the enable is low must leave no trace
  task t_freeze();
    @(posedge clk);
    clkEn <= 1'b0;
    st <= 12'h017;
    host.wr(ASM_OFF_CLK_FAULT, 8'hFF);
    st <= 12'h006;
    clkEn <= 1'b1;
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    $display("clock enable freeze done");
  endtask : t_freeze

  // A mid-run reset drops latched events and returns to page 0
  task t_rst();
    host.wr(ASM_OFF_PAGE_SEL, ASM_PAGE1);
    setst(12'h017);
    @(posedge clk);
    rst_n <= 1'b0;
    st <= 12'h006;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pageSelect, ASM_PAGE0);
    rc(ASM_OFF_CLK_FAULT, 8'h00);
    $display("mid-run reset done");
  endtask : t_rst

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_live();
    t_mon();
    t_amp();
    t_freeze();
    t_rst();
    final_report();
  end
endmodule : test_asm_status_monitor
